// File: rtl/adc_serial_channel_interface.sv
// Purpose: Serial control, channel select and readout of the converter
// Assumes: Pins are asynchronous to core_clk and sampled by three flops
// Notes:   Pin outputs come with an output enable each
//
// Notes on behaviour
// RQ1: Reset selects input 0 positive, input 1 negative, converting at once.
// RQ2: Host starts each word with 000, 100 or 101 only.
// RQ3: Leading 000 or 100 keeps the previous channel.
// RQ4: Leading 101 takes the next five bits as the new channel.
// RQ5: First selection bit picks differential pair or single-ended input.
// RQ6: Pair bit picks pair, odd bit sets polarity or single channel.
// RQ7: Conversions timed by internal oscillator or clock on the select pin.
// RQ8: Serial clock level at power-up and select fall picks clock source.
// RQ9: Data output floats while deselected, else shows conversion busy flag.
// RQ10: Completion enters sleep; result waits in shift register until clocked.
// RQ11: Input sampled on every rising edge, output updated on falling edges; the code samples only the first eight rises.
// RQ12: A new channel applies to the conversion after the data cycle.
// RQ13: Host latches busy flag on rise one and last bit on rise 24.
// RQ14: External clock: 24th falling edge starts conversion, output goes high.
// RQ15: External mode: select rise mid-frame aborts and starts a conversion.
// RQ16: Abort before falling edge eight keeps old channel, after loads new.
// RQ17: Select tied low: clock level before power-on end picks source.
// RQ18: Select tied low: busy flag always shown; result loaded when it drops.
// RQ19: Internal mode: select fall drives clock low, pull-up active then; the code turns the pull-up off while it drives the clock low.
// RQ20: Done result: first clock rise after probe delay unless select rises.
// RQ21: Internal mode: after rise 24 convert, output high, clock held high.
// RQ22: Internal mode: select rise mid-frame aborts with same channel rule.
// RQ23: Frame is flag, zero, sign, 17 result bits, four zeros.
// RQ24: Eight-bit select word shifts in alongside the output frame.
// RQ25: Unsupported leading codes keep the previous channel.
// RQ26: Edge counts clear at each abort or new conversion.

`timescale 1ns/1ps

module adc_serial_channel_interface #(
    parameter int POR_CYCLES = adc_serial_pkg::POR_CYCLES_DEF,
    parameter int CONV_CYCLES = adc_serial_pkg::CONV_CYCLES_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic sck_pullup_en,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic osc_select_pin,
    // Converter core
    input wire logic [adc_serial_pkg::RESULT_BITS-1:0] conv_result,
    output logic conv_busy,
    output logic ext_clock_mode,
    // Channel selection
    output logic single_ended_sel,
    output logic odd_sel,
    output logic upper_addr_bit_hi,
    output logic upper_addr_bit_lo,
    output logic pair_sel,
    output logic [2:0] pos_channel,
    output logic [2:0] neg_channel
);
    import adc_serial_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers {osc, sdi, sck, cs}
    // ------------------------------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] clean;
    logic [3:0] clean_d;
    wire [3:0] next_clean = (~(sync2 ^ sync3) & sync3)
        | ((sync2 ^ sync3) & clean);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 4'h1;
            sync2 <= 4'h1;
            sync3 <= 4'h1;
            clean <= 4'h1;
            clean_d <= 4'h1;
        end else begin
            sync1 <= {osc_select_pin, sdi, sck_in, cs_n};
            sync2 <= sync1;
            sync3 <= sync2;
            clean <= next_clean;
            clean_d <= clean;
        end
    end

    wire cs_low = !clean[0];
    wire cs_fall = clean_d[0] && !clean[0];
    wire cs_rise = !clean_d[0] && clean[0];
    wire sck_hi = clean[1];
    wire sck_rise_pin = clean[1] && !clean_d[1];
    wire sck_fall_pin = !clean[1] && clean_d[1];
    wire sdi_v = clean[2];
    wire osc_rise = clean[3] && !clean_d[3];

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    state_type state;
    state_type next_state;
    logic ext_mode;
    logic por_done;
    logic [19:0] por_cnt;
    logic [19:0] conv_cnt;
    logic [11:0] probe_cnt;
    logic [4:0] half_cnt;
    logic [6:0] osc_idle;
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [7:0] in_word;
    logic [4:0] chan;
    logic [FRAME_BITS-1:0] shreg;
    logic loaded;

    result_buf_if #(.WIDTH(RESULT_BITS)) rbuf ();

    result_buffer #(.WIDTH(RESULT_BITS)) u_buffer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .bus(rbuf.store)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire int_osc = (osc_idle == OSC_IDLE_MAX) && !clean[3]; // RQ7
    wire tick = int_osc || osc_rise; // RQ7
    wire por_end = !por_done && (por_cnt == 20'(POR_CYCLES - 1));
    wire conv_done = (state == ST_CONVERT) && tick
        && (conv_cnt == 20'(CONV_CYCLES - 1));
    wire probe_done = (state == ST_PROBE)
        && (int_osc ? (probe_cnt == PROBE_LAST)
                    : (osc_rise && probe_cnt == OSC_PROBE_LAST)); // RQ20
    wire half_tick = (state == ST_DATA) && !ext_mode
        && (half_cnt == SCK_HALF_LAST);
    wire int_rise = probe_done || (half_tick && !sck_out);
    wire int_fall = half_tick && sck_out;
    wire rise_ev = ext_mode ? (cs_low && sck_rise_pin) : int_rise;
    wire fall_ev = ext_mode ? (cs_low && sck_fall_pin) : int_fall;
    wire start_data = probe_done || ((state == ST_SLEEP) && ext_mode
        && por_done && loaded && rise_ev); // RQ10
    wire in_cycle = (state == ST_DATA) || start_data;
    wire take_rise = in_cycle && rise_ev; // RQ11
    wire data_end = (state == ST_DATA) && (ext_mode
        ? (fall_ev && fall_cnt == LAST_EDGE) // RQ14
        : (rise_ev && rise_cnt == LAST_EDGE)); // RQ21
    wire abort = (state == ST_DATA) && cs_rise && !data_end; // RQ15 RQ22
    wire new_conv = data_end || abort;
    wire load_ok = data_end || (fall_cnt >= LOAD_FALLS); // RQ16
    wire code_ok = (in_word[7:5] == ENABLE_CODE); // RQ3 RQ25
    wire apply = new_conv && load_ok && code_ok; // RQ4 RQ12
    wire [4:0] next_chan = apply ? in_word[4:0] : chan;
    wire [5:0] route = chan_route(next_chan); // RQ5 RQ6
    wire next_ext = !sck_hi;

    assign rbuf.wr_valid = conv_done;
    assign rbuf.wr_data = conv_result;
    assign rbuf.rd_ready = (state == ST_SLEEP) && !loaded;

    always_comb begin
        next_state = state;
        case (state)
            ST_CONVERT: begin
                if (conv_done && rbuf.wr_ready) begin
                    next_state = ST_SLEEP; // RQ10
                end
            end
            ST_SLEEP: begin
                if (start_data) begin
                    next_state = ST_DATA;
                end else if (!ext_mode && por_done && loaded && cs_low
                             && !cs_rise) begin
                    next_state = ST_PROBE; // RQ19
                end
            end
            ST_PROBE: begin
                if (cs_rise) begin
                    next_state = ST_SLEEP; // RQ20
                end else if (probe_done) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (new_conv) begin
                    next_state = ST_CONVERT;
                end
            end
            default: begin
                next_state = ST_CONVERT;
            end
        endcase
    end

    logic next_sdo;
    always_comb begin
        if (new_conv) begin
            next_sdo = 1'b1; // RQ14 RQ21
        end else if ((state == ST_DATA) && fall_ev) begin
            next_sdo = shreg[FRAME_BITS-2]; // RQ11 RQ23
        end else if (in_cycle) begin
            next_sdo = sdo_out;
        end else begin
            next_sdo = (state == ST_CONVERT); // RQ9 RQ18
        end
    end

    logic next_sck;
    always_comb begin
        if (new_conv || probe_done) begin
            next_sck = 1'b1; // RQ21
        end else if (cs_fall && !next_ext) begin
            next_sck = 1'b0; // RQ19
        end else if ((state == ST_SLEEP) && (next_state == ST_PROBE)) begin
            next_sck = 1'b0; // RQ19
        end else if (half_tick) begin
            next_sck = !sck_out;
        end else begin
            next_sck = sck_out;
        end
    end

    // ------------------------------------------------------------
    // Mode, timers and conversion
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            por_cnt <= 20'h00000;
            por_done <= 1'b0;
            ext_mode <= 1'b0;
        end else begin
            por_cnt <= por_done ? por_cnt : por_cnt + 20'h00001;
            por_done <= por_done || por_end;
            if (por_end || cs_fall) begin
                ext_mode <= next_ext; // RQ8 RQ17
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_CONVERT; // RQ1
            conv_cnt <= 20'h00000;
            osc_idle <= 7'h00;
            probe_cnt <= 12'h000;
            half_cnt <= 5'h00;
        end else begin
            state <= next_state;
            if (clean[3] != clean_d[3]) begin
                osc_idle <= 7'h00;
            end else if (osc_idle != OSC_IDLE_MAX) begin
                osc_idle <= osc_idle + 7'h01;
            end
            if (state != ST_CONVERT) begin
                conv_cnt <= 20'h00000;
            end else if (tick && !conv_done) begin
                conv_cnt <= conv_cnt + 20'h00001; // RQ7
            end
            if (state != ST_PROBE) begin
                probe_cnt <= 12'h000;
            end else if (int_osc || osc_rise) begin
                probe_cnt <= probe_cnt + 12'h001;
            end
            half_cnt <= (state == ST_DATA && !half_tick)
                ? half_cnt + 5'h01 : 5'h00;
        end
    end

    // ------------------------------------------------------------
    // Data cycle shifters and channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_cnt <= 5'h00;
            fall_cnt <= 5'h00;
            in_word <= 8'h00;
            shreg <= '0;
            loaded <= 1'b0;
            chan <= CHAN_RESET; // RQ1
        end else begin
            chan <= next_chan; // RQ4 RQ16
            if (new_conv) begin
                rise_cnt <= 5'h00; // RQ26
                fall_cnt <= 5'h00; // RQ26
                in_word <= 8'h00;
                loaded <= 1'b0;
            end else begin
                if (take_rise) begin
                    rise_cnt <= rise_cnt + 5'h01;
                    if (rise_cnt < WORD_RISES) begin
                        in_word <= {in_word[6:0], sdi_v}; // RQ24
                    end
                end
                if ((state == ST_DATA) && fall_ev) begin
                    fall_cnt <= fall_cnt + 5'h01;
                    shreg <= {shreg[FRAME_BITS-2:0], 1'b0}; // RQ11
                end
                if (rbuf.rd_ready && rbuf.rd_valid) begin
                    shreg <= frame_of(rbuf.rd_data); // RQ18 RQ23
                    loaded <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_out <= 1'b1;
            sdo_oe <= 1'b0;
            sck_out <= 1'b1;
            sck_oe <= 1'b0;
            sck_pullup_en <= 1'b1;
            conv_busy <= 1'b1;
            pos_channel <= 3'h0;
            neg_channel <= 3'h1;
        end else begin
            sdo_out <= next_sdo;
            sdo_oe <= cs_low; // RQ9
            sck_out <= next_sck;
            sck_oe <= !ext_mode && cs_low && por_done; // RQ19
            sck_pullup_en <= !(sck_oe && !sck_out); // RQ19
            conv_busy <= (next_state == ST_CONVERT);
            pos_channel <= route[5:3];
            neg_channel <= route[2:0];
        end
    end

    assign ext_clock_mode = ext_mode;
    assign single_ended_sel = chan[4];
    assign odd_sel = chan[3];
    assign upper_addr_bit_hi = chan[2];
    assign upper_addr_bit_lo = chan[1];
    assign pair_sel = chan[0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_sdo_float;
        !cs_low |=> !sdo_oe;
    endproperty
    a_sdo_float: assert property (p_sdo_float) // RQ9
        else $error("data output driven while deselected");

    property p_keep_chan;
        new_conv && !code_ok |=> $stable(chan);
    endproperty
    a_keep_chan: assert property (p_keep_chan) // RQ3
        else $error("channel changed without enable code");

    property p_load_chan;
        data_end && code_ok |=> chan == $past(in_word[4:0]);
    endproperty
    a_load_chan: assert property (p_load_chan) // RQ4
        else $error("channel not loaded at end of frame");

    property p_early_abort;
        abort && fall_cnt < 5'h08 |=> $stable(chan);
    endproperty
    a_early_abort: assert property (p_early_abort) // RQ16
        else $error("early abort changed channel");

    property p_sleep;
        conv_done && rbuf.wr_ready |=> state == ST_SLEEP ##1 !sdo_out;
    endproperty
    a_sleep: assert property (p_sleep) // RQ10
        else $error("no sleep after conversion");

    property p_ext_end;
        ext_mode && data_end |=> sdo_out && state == ST_CONVERT;
    endproperty
    a_ext_end: assert property (p_ext_end) // RQ14
        else $error("output not high after last falling edge");

    property p_mode_pick;
        cs_fall |=> ext_clock_mode == !$past(sck_hi);
    endproperty
    a_mode_pick: assert property (p_mode_pick) // RQ8
        else $error("clock source not taken at select fall");

    property p_int_low;
        cs_fall && sck_hi && por_done && !new_conv && !probe_done
            |=> !sck_out ##1 sck_oe ##1 !sck_pullup_en;
    endproperty
    a_int_low: assert property (p_int_low) // RQ19
        else $error("clock not pulled low at select fall");

    property p_sample;
        take_rise && rise_cnt < 5'h08 && !new_conv
            |=> in_word[0] == $past(sdi_v);
    endproperty
    a_sample: assert property (p_sample) // RQ11
        else $error("input bit not sampled on rise");

    property p_count_clear;
        new_conv |=> rise_cnt == 5'h00 && fall_cnt == 5'h00;
    endproperty
    a_count_clear: assert property (p_count_clear) // RQ26
        else $error("edge counts not cleared");

    c_ext_frame: cover property (ext_mode && data_end);
    c_abort: cover property (abort && load_ok);
    c_probe_back: cover property (state == ST_PROBE && cs_rise);
    c_int_frame: cover property (!ext_mode && data_end);
endmodule : adc_serial_channel_interface

// File: rtl/adc_serial_pkg.sv
// Purpose: Shared constants, types and helpers of the converter serial port
// Assumes: Core clock of 200 MHz (5 ns)
// Notes:   Cycle counts are derived from the printed times

package adc_serial_pkg;

    // ------------------------------------------------------------
    // Frame and word layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int WORD_BITS = 8;
    localparam int RESULT_BITS = 18;
    localparam int CHAN_LOAD_FALLS = 8;
    localparam logic [2:0] ENABLE_CODE = 3'h5;
    localparam logic [4:0] CHAN_RESET = 5'h00;
    localparam logic [2:0] COMMON_INDEX = 3'h4;
    localparam logic [4:0] LAST_EDGE = 5'(FRAME_BITS - 1);
    localparam logic [4:0] LOAD_FALLS = 5'(CHAN_LOAD_FALLS);
    localparam logic [4:0] WORD_RISES = 5'(WORD_BITS);

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CORE_PERIOD_PS = 5000;
    localparam int PROBE_DELAY_NS = 12000;
    localparam int PROBE_CYCLES =
        (PROBE_DELAY_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    localparam logic [11:0] PROBE_LAST = 12'(PROBE_CYCLES - 1);
    localparam int OSC_PROBE_TENTHS = 36;
    localparam int OSC_PROBE_EDGES = (OSC_PROBE_TENTHS + 9) / 10;
    localparam logic [11:0] OSC_PROBE_LAST = 12'(OSC_PROBE_EDGES - 1);
    localparam int POR_TIME_US = 4000;
    localparam int POR_CYCLES_DEF =
        POR_TIME_US * (1000000 / CORE_PERIOD_PS);
    localparam int CONV_CYCLES_DEF = 8192;
    localparam logic [4:0] SCK_HALF_LAST = 5'h0F;
    localparam logic [6:0] OSC_IDLE_MAX = 7'h40;

    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CONVERT = 4'h1,
        ST_SLEEP = 4'h2,
        ST_PROBE = 4'h4,
        ST_DATA = 4'h8
    } state_type;

    // Selection {single, odd, hi, lo, pair} to {positive, negative}
    function automatic logic [5:0] chan_route(input logic [4:0] sel);
        logic [2:0] base;
        base = {1'b0, sel[0], 1'b0};
        if (sel[4]) begin
            chan_route = {base | {2'h0, sel[3]}, COMMON_INDEX};
        end else begin
            chan_route = {base | {2'h0, sel[3]}, base | {2'h0, ~sel[3]}};
        end
    endfunction : chan_route

    function automatic logic [FRAME_BITS-1:0] frame_of(
        input logic [RESULT_BITS-1:0] res);
        frame_of = {2'h0, res, 4'h0};
    endfunction : frame_of

endpackage : adc_serial_pkg

// File: rtl/result_buf_if.sv
// Purpose: Carrier between the serial port and its result buffer
// Assumes: Valid and ready handshake on both sides
// Notes:   A word moves when valid and ready are both high

`timescale 1ns/1ps

interface result_buf_if #(parameter int WIDTH = 18);
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport store (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data
    );
endinterface : result_buf_if

// File: rtl/result_buffer.sv
// Purpose: Two-entry buffer for finished conversion results
// Assumes: Single clock domain
// Notes:   Full stalls the converter; empty holds off the shifter

`timescale 1ns/1ps

module result_buffer #(parameter int WIDTH = 18) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Buffer ports
    result_buf_if.store bus
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = bus.wr_valid && bus.wr_ready;
    wire pop = bus.rd_valid && bus.rd_ready;

    assign bus.wr_ready = (count != 2'h2);
    assign bus.rd_valid = (count != 2'h0);
    assign bus.rd_data = mem[rd_ptr];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= bus.wr_data;
        end
    end
endmodule : result_buffer

// File: tb/host_serial_model.sv
// Purpose: Host controller on the serial pins, external clock mode
// Assumes: Serial clock half period 32 ns, held low outside frames
// Notes:   Released data line reads as the inverse of its last level

`timescale 1ns/1ps

module host_serial_model (
    // Serial pins
    output logic cs_n,
    output logic sck_in,
    output logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    logic sdo_last = 1'b0;
    logic sdo_line;

    assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;

    always @(sdo_out or sdo_oe) begin
        if (sdo_oe) sdo_last = sdo_out;
    end

    initial begin
        cs_n = 1'b1;
        sck_in = 1'b0;
        sdi = 1'b0;
    end

    task automatic xfer(input logic [7:0] word, input int falls,
                        output logic [23:0] got);
        got = '0;
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < falls; i++) begin
            sdi = (i < 8) ? word[7 - i] : ~sdi;
            #32 sck_in = 1'b1;
            got[23 - i] = sdo_line;
            #32 sck_in = 1'b0;
        end
        sdi = ~sdi;
        if (falls < 24) begin
            #40 cs_n = 1'b1;
        end
    endtask : xfer

    task automatic float_sck();
        sck_in = 1'b1;
        #20 cs_n = 1'b0;
    endtask : float_sck

    task automatic deselect();
        #40 cs_n = 1'b1;
    endtask : deselect
endmodule : host_serial_model

// File: tb/test_adc_serial_channel_interface.sv
// Purpose: Self-checking bench of the converter serial port
// Assumes: External serial clock, then internal; internal oscillator, then clock on the select pin
// Notes:   Short power-on and conversion counts

`timescale 1ns/1ps

module test_adc_serial_channel_interface;
    import adc_serial_pkg::*;
    localparam int POR = 50;
    localparam int CONV = 100;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic osc_select_pin = 1'b0;
    logic cs_n, sck_in, sdi, sck_out, sck_oe, sck_pullup_en;
    logic sdo_out, sdo_oe, conv_busy, ext_clock_mode;
    logic single_ended_sel, odd_sel, pair_sel;
    logic upper_addr_bit_hi, upper_addr_bit_lo;
    logic [2:0] pos_channel, neg_channel;
    logic [RESULT_BITS-1:0] conv_result, held, res;
    logic [31:0] lfsr = 32'hE706;
    logic [23:0] got;
    logic [5:0] chan;
    logic [7:0] word;
    logic [2:0] codes [4] = '{3'h5, 3'h0, 3'h4, 3'h7};
    int miscompares = 0;
    int comparisons = 0;
    int falls;
    logic [4:0] sel = 5'h00;
    logic osc_run = 1'b0;

    always #40 begin
        if (osc_run || osc_select_pin) osc_select_pin = ~osc_select_pin;
    end

    initial forever #2.5 core_clk = ~core_clk;

    adc_serial_channel_interface #(.POR_CYCLES(POR), .CONV_CYCLES(CONV)) dut (
        .core_clk, .arst_n, .cs_n, .sck_in, .sck_out, .sck_oe,
        .sck_pullup_en, .sdi, .sdo_out, .sdo_oe, .osc_select_pin,
        .conv_result, .conv_busy, .ext_clock_mode, .single_ended_sel,
        .odd_sel, .upper_addr_bit_hi, .upper_addr_bit_lo, .pair_sel,
        .pos_channel, .neg_channel
    );

    host_serial_model host (.cs_n, .sck_in, .sdi, .sdo_out, .sdo_oe);

    // ----
    // Expectations and checks
    // ----
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : step

    function automatic logic [5:0] route(input logic [7:0] w);
        return {1'b0, w[0], w[3], w[4] ? 3'h4 : {1'b0, w[0], ~w[3]}};
    endfunction : route

    task automatic chk_bit(input logic g, input logic e, input string s);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t: %s got %b", $time, s, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [23:0] g, input logic [23:0] e,
                           input string s);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t: %s got %h want %h", $time, s, g, e);
        end
    endtask : chk_vec

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic wait_done();
        for (int i = 0; i < 4000 && conv_busy !== 1'b0; i++) begin
            @(posedge core_clk);
        end
        if (conv_busy !== 1'b0) begin
            miscompares++;
            conclude();
        end
    endtask : wait_done

    // ----
    // Main sequence
    // ----
    initial begin
        conv_result = lfsr[RESULT_BITS-1:0];
        held = conv_result;
        chan = 6'h01;
        repeat (16) @(posedge core_clk);
        #1 arst_n = 1'b1;
        @(posedge core_clk);
        #1 chk_vec(24'({pos_channel, neg_channel}), 24'(chan), "reset");
        chk_bit(conv_busy, 1'b1, "first conversion");
        repeat (POR + 20) @(posedge core_clk);
        #1 chk_bit(ext_clock_mode, 1'b1, "clock source");
        for (int k = 0; k < 20; k++) begin
            lfsr = step(lfsr);
            osc_run = (k >= 16);
            falls = (k == 4) ? 5 : (k == 8) ? 8 : (k == 12) ? 7 : 24;
            word = {codes[k % 4], lfsr[0], lfsr[1], 2'h0, lfsr[2]};
            wait_done();
            @(posedge core_clk);
            #1 chk_bit(sdo_oe, 1'b0, "released output");
            res = held;
            lfsr = step(lfsr);
            held = lfsr[RESULT_BITS-1:0];
            conv_result = held;
            host.xfer(word, falls, got);
            if (word[7:5] == ENABLE_CODE && falls >= 8) begin
                chan = route(word);
                sel = word[4:0];
            end
            chk_bit(got[23], 1'b0, "done flag");
            repeat (20) @(posedge core_clk);
            #1 chk_bit(conv_busy, 1'b1, "new conversion");
            if (osc_run) begin
                repeat (200) @(posedge core_clk);
                #1 chk_bit(conv_busy, 1'b1, "slow clock");
            end
            if (falls == 24) begin
                chk_vec(got, {2'h0, res, 4'h0}, "frame");
                chk_bit(sdo_out, 1'b1, "busy shown");
                host.deselect();
            end
            chk_vec(24'({pos_channel, neg_channel}), 24'(chan), "chan");
            got = 24'({single_ended_sel, odd_sel, upper_addr_bit_hi,
                       upper_addr_bit_lo, pair_sel});
            chk_vec(got, 24'(sel), "sel");
        end
        osc_run = 1'b0;
        wait_done();
        repeat (100) @(posedge core_clk);
        #1 host.float_sck();
        repeat (20) @(posedge core_clk);
        #1 chk_bit(ext_clock_mode, 1'b0, "internal source");
        chk_bit(sck_oe, 1'b1, "clock driven");
        chk_bit(sck_out, 1'b0, "clock low");
        chk_bit(sck_pullup_en, 1'b0, "pull-up off");
        chk_bit(sdo_out, 1'b0, "done flag internal");
        repeat (3160) @(posedge core_clk);
        #1 chk_bit(conv_busy, 1'b1, "internal frame end");
        chk_bit(sck_out, 1'b1, "clock held high");
        chk_bit(sdo_out, 1'b1, "busy after frame");
        host.deselect();
        conclude();
    end
endmodule : test_adc_serial_channel_interface
